//--- pfws_flash.sv
/*
 Burst flasher: shows a number of pulses then a gap, or a steady level.
 Assumes tick is a one-cycle pulse from the shared prescaler.
*/
`timescale 1ns/1ps
module pfws_flash
	import pfws_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       arst_n,
	// timing and pattern
	input  wire logic       tick,
	input  wire logic [2:0] pattern,
	// lamp
	output logic            lamp
);
	import pfws_pkg::*;

	logic [15:0] phase_reg;
	logic [2:0]  count_reg;
	logic        on_reg;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			phase_reg <= 16'h0000;
			count_reg <= 3'd0;
			on_reg    <= 1'b0;
		end
		else if (pattern == PAT_OFF || pattern == PAT_STEADY)
		begin
			phase_reg <= 16'h0000;
			count_reg <= 3'd0;
			on_reg    <= 1'b0;
		end
		else if (tick)
		begin
			phase_reg <= phase_reg + 16'h0001;
			if (on_reg && phase_reg >= 16'(FLASH_ON_TICKS - 1))
			begin
				on_reg    <= 1'b0;
				phase_reg <= 16'h0000;
				count_reg <= count_reg + 3'd1;
			end
			else if (!on_reg && count_reg < pattern && phase_reg >= 16'(FLASH_ON_TICKS - 1))
			begin
				on_reg    <= 1'b1;
				phase_reg <= 16'h0000;
			end
			// long gap after the burst lets the eye count the pulses
			else if (!on_reg && count_reg >= pattern && phase_reg >= 16'(FLASH_GAP_TICKS - 1))
			begin
				count_reg <= 3'd0;
				phase_reg <= 16'h0000;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			lamp <= 1'b0;
		else
			lamp <= (pattern == PAT_STEADY) | on_reg;
	end

endmodule : pfws_flash

//--- pfws_pkg.sv
/*
 Shared constants and carrier types for the pump fault and warning supervisor.
 Assumes a 100 MHz system clock; sensor figures arrive already digitised.
*/
package pfws_pkg;

	localparam int unsigned CLK_HZ            = 100_000_000;
	localparam int unsigned TICK_MS           = 1;
	localparam int unsigned TICK_CYC          = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned PWR_LOSS_MS       = 2000;
	localparam int unsigned PWR_LOSS_TICKS    = PWR_LOSS_MS / TICK_MS;
	localparam int unsigned OVLD_MIN          = 15;
	localparam int unsigned OVLD_TICKS        = OVLD_MIN * 60 * 1000 / TICK_MS;
	localparam int unsigned CONTACT_MS        = 500;
	localparam int unsigned CONTACT_TICKS     = CONTACT_MS / TICK_MS;
	localparam int unsigned HOUR_TICKS        = 3600 * 1000 / TICK_MS;
	localparam int unsigned FLASH_ON_MS       = 200;
	localparam int unsigned FLASH_ON_TICKS    = FLASH_ON_MS / TICK_MS;
	localparam int unsigned FLASH_GAP_MS      = 1000;
	localparam int unsigned FLASH_GAP_TICKS   = FLASH_GAP_MS / TICK_MS;

	localparam logic [15:0] SUPPLY_MIN_DV     = 16'd430;
	localparam logic [15:0] SPEED_LAND_RPM    = 16'd20000;
	localparam logic [15:0] SPEED_OVER_RPM    = 16'd58500;
	localparam logic [15:0] SPEED_RATED_RPM   = 16'd45000;
	localparam logic [11:0] MOTOR_MAX_DC      = 12'd1100;
	localparam logic [11:0] CTRL_MAX_DC       = 12'd800;
	localparam logic [11:0] IMBAL_LIMIT       = 12'h200;
	localparam logic [7:0]  DAMAGE_LIMIT      = 8'd120;
	localparam logic [7:0]  DAMAGE_MAX        = 8'hFF;
	localparam logic [3:0]  DAMAGE_DIST_MAX   = 4'd15;
	localparam logic [7:0]  DAMAGE_LAND_PTS   = 8'd1;
	localparam logic [15:0] RUNTIME_STEP_H    = 16'd100;
	localparam logic [31:0] RUNTIME_MAX       = 32'hFFFF_FFFF;

	// flash pattern selector: 0 off, 1..3 bursts, 4 steady
	localparam logic [2:0]  PAT_OFF           = 3'd0;
	localparam logic [2:0]  PAT_STEADY        = 3'd4;

	typedef struct packed {
		logic [15:0] supply_dv;
		logic [15:0] speed_rpm;
		logic [11:0] motor_temp_dc;
		logic [11:0] ctrl_temp_dc;
		logic [11:0] imbalance;
		logic        bearing_ok;
		logic        contact;
		logic        accelerating_state;
		logic        braking_state;
	} pfws_sense_t;

	typedef struct packed {
		logic power_fail;
		logic overspeed;
		logic motor_overtemp;
		logic controller_overtemp_fault;
		logic driver_overload_fault;
		logic disturbance;
	} pfws_fault_t;

	typedef struct packed {
		logic damage_limit;
		logic runtime_over;
		logic imbalance;
	} pfws_warn_t;

endpackage : pfws_pkg

//--- pfws_pump_model.sv
/*
 Behavioural pump and sensor front end facing the supervisor.
 Assumes the bench sets raw readings; drive states follow the orders.
*/
`timescale 1ns/1ps
module pfws_pump_model
	import pfws_pkg::*;
(
	// raw readings from the bench
	input  pfws_pkg::pfws_sense_t knob,
	// drive orders from the supervisor
	input  wire logic             accel_cmd,
	input  wire logic             decel_cmd,
	// digitised sensor word
	output pfws_pkg::pfws_sense_t sense
);
	// accelerating only while ordered and still short of rated speed
	always_comb
	begin
		sense                    = knob;
		sense.accelerating_state = accel_cmd && (knob.speed_rpm < SPEED_RATED_RPM);
		sense.braking_state      = decel_cmd;
	end
endmodule : pfws_pump_model

//--- pfws_supervisor.sv
/*
 Pump fault and warning supervisor: power-loss handling, fault latching,
 deceleration order, lamps, remote contacts and maintenance warnings.
 Assumes sensor words and host strobes are synchronous to clk.
*/
// Behaviour
// - supply below 43 V is a candidate power loss
// - loss over 2 s at high speed flags power failure and decelerates
// - loss shorter than 2 s at high speed changes nothing
// - loss at low speed: power lamp off, power-good open, failure contact idle
// - after flagged failure, landing near 20,000 rpm turns all lamps off
// - supply recovery clears power failure flag, deceleration continues
// - start after recovery re-accelerates even while braking
// - vibration on recovery after landing blocks start until fault reset
// - bearing malfunction stops rotor, lights failure lamp, asserts output
// - persistent backup contact decelerates, flashes lamp, asserts output
// - fifteen minutes accelerating raises driver overload and stops
// - motor above 110 C raises overheat fault and stops
// - controller above 80 C raises overheat fault and stops
// - speed above 58,500 rpm raises overspeed, steady lamp, stops
// - warnings flash orange three, two or one; highest shown only
// - any warning asserts a separate remote warning output
// - fault reset leaves warnings; only warning configuration clears
// - warnings never inhibit starting or running
// - damage score reaching 120 raises damage limit warning
// - disturbance adds up to 15 by speed; landing adds 1
// - running hours reaching configured limit raises run-time warning
// - imbalance above fixed threshold raises imbalance warning
// - failure lamp shows highest-priority fault pattern
// - run-time limit in 100-hour steps; zero disables
`timescale 1ns/1ps
module pfws_supervisor
	import pfws_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYC,
	parameter int unsigned LOSS_TICKS  = PWR_LOSS_TICKS,
	parameter int unsigned OVLD_LIMIT  = OVLD_TICKS,
	parameter int unsigned CONT_TICKS  = CONTACT_TICKS,
	parameter int unsigned HOUR_LEN    = HOUR_TICKS
)
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// sensing
	input  pfws_pkg::pfws_sense_t sense,
	// host commands, one-cycle strobes
	input  wire logic        start_req,
	input  wire logic        fault_reset_req,
	// warning configuration
	input  wire logic [2:0]  warn_enable,
	input  wire logic        warn_clear,
	input  wire logic [15:0] runtime_limit_steps,
	// drive orders
	output logic             decel_cmd,
	output logic             accel_cmd,
	// lamps
	output logic             power_lamp,
	output logic             failure_lamp_red,
	output logic             failure_lamp_orange,
	// remote_io_connector contacts
	output logic             power_good_closed,
	output logic             failure_no_closed,
	output logic             failure_nc_closed,
	output logic             warning_out,
	// status for the serial host
	output pfws_pkg::pfws_fault_t faults,
	output pfws_pkg::pfws_warn_t  warnings,
	output logic [7:0]       damage_score,
	output logic [31:0]      run_hours
);
	import pfws_pkg::*;

	typedef enum logic [1:0] {PFWS_STOPPED, PFWS_RUNNING, PFWS_DECEL, PFWS_LOCKED} pfws_state_t;

	pfws_state_t state_reg;
	logic [31:0] pre_reg;
	logic        tick;
	logic [31:0] loss_cnt_reg;
	logic [31:0] ovld_cnt_reg;
	logic [31:0] cont_cnt_reg;
	logic [31:0] hour_cnt_reg;
	logic        loss_hi_reg;
	logic        loss_lo_reg;
	logic        landed_reg;
	logic        contact_q_reg;
	logic        supply_low;
	logic        high_speed;
	logic        any_fault;
	logic [2:0]  red_pat;
	logic [2:0]  orange_pat;
	logic [7:0]  dist_pts;
	logic [8:0]  damage_sum;
	logic [31:0] limit_hours;
	logic        dist_event;
	logic        land_event;
	logic        lamps_dark;
	logic        fault_cause;

	assign supply_low = sense.supply_dv < SUPPLY_MIN_DV;
	assign high_speed = sense.speed_rpm >= SPEED_LAND_RPM;

	// prescaler
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			pre_reg <= 32'h0000_0000;
		else if (pre_reg >= TICK_CYCLES - 1)
			pre_reg <= 32'h0000_0000;
		else
			pre_reg <= pre_reg + 32'h0000_0001;
	end
	assign tick = (pre_reg >= TICK_CYCLES - 1);

	// supply-loss timer; the speed is sampled when the loss starts
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			loss_cnt_reg <= 32'h0000_0000;
			loss_lo_reg  <= 1'b0;
		end
		else if (!supply_low)
		begin
			loss_cnt_reg <= 32'h0000_0000;
			loss_lo_reg  <= 1'b0;
		end
		else
		begin
			if (loss_cnt_reg == 32'h0000_0000 && !high_speed)
				loss_lo_reg <= 1'b1;
			if (tick && loss_cnt_reg < LOSS_TICKS)
				loss_cnt_reg <= loss_cnt_reg + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			loss_hi_reg <= 1'b0;
		else if (!supply_low)
			loss_hi_reg <= 1'b0;
		else if (!loss_lo_reg && loss_cnt_reg >= LOSS_TICKS)
			loss_hi_reg <= 1'b1;
	end

	// landing on the backup bearing after a flagged failure
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			landed_reg <= 1'b0;
		else if (loss_hi_reg && !high_speed)
			landed_reg <= 1'b1;
		else if (!supply_low)
			landed_reg <= 1'b0;
	end
	assign land_event = loss_hi_reg && !high_speed && !landed_reg;
	assign lamps_dark = landed_reg && supply_low;

	// backup contact persistence
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			cont_cnt_reg <= 32'h0000_0000;
		else if (!sense.contact)
			cont_cnt_reg <= 32'h0000_0000;
		else if (tick && cont_cnt_reg < CONT_TICKS)
			cont_cnt_reg <= cont_cnt_reg + 32'h0000_0001;
	end

	// accelerating time
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			ovld_cnt_reg <= 32'h0000_0000;
		else if (state_reg != PFWS_RUNNING || !sense.accelerating_state
			|| sense.speed_rpm >= SPEED_RATED_RPM)
			ovld_cnt_reg <= 32'h0000_0000;
		else if (tick && ovld_cnt_reg < OVLD_LIMIT)
			ovld_cnt_reg <= ovld_cnt_reg + 32'h0000_0001;
	end

	// latched faults, except power_fail which follows the loss; a new event wins over a reset in the same cycle
	// a bearing malfunction is a disturbance too and scores like a persistent contact
	assign dist_event = (!sense.bearing_ok || cont_cnt_reg >= CONT_TICKS)
		&& !faults.disturbance;
	// causes as they stand now, so one reset releases the lock once they are gone
	assign fault_cause = sense.speed_rpm > SPEED_OVER_RPM || sense.motor_temp_dc > MOTOR_MAX_DC
		|| sense.ctrl_temp_dc > CTRL_MAX_DC || ovld_cnt_reg >= OVLD_LIMIT
		|| !sense.bearing_ok || cont_cnt_reg >= CONT_TICKS;
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			faults <= '0;
		else
		begin
			faults.power_fail <= loss_hi_reg;
			if (sense.speed_rpm > SPEED_OVER_RPM)
				faults.overspeed <= 1'b1;
			else if (fault_reset_req)
				faults.overspeed <= 1'b0;
			if (sense.motor_temp_dc > MOTOR_MAX_DC)
				faults.motor_overtemp <= 1'b1;
			else if (fault_reset_req)
				faults.motor_overtemp <= 1'b0;
			if (sense.ctrl_temp_dc > CTRL_MAX_DC)
				faults.controller_overtemp_fault <= 1'b1;
			else if (fault_reset_req)
				faults.controller_overtemp_fault <= 1'b0;
			if (ovld_cnt_reg >= OVLD_LIMIT)
				faults.driver_overload_fault <= 1'b1;
			else if (fault_reset_req)
				faults.driver_overload_fault <= 1'b0;
			if (!sense.bearing_ok || cont_cnt_reg >= CONT_TICKS)
				faults.disturbance <= 1'b1;
			else if (fault_reset_req)
				faults.disturbance <= 1'b0;
		end
	end
	assign any_fault = faults.overspeed | faults.motor_overtemp | faults.controller_overtemp_fault
		| faults.driver_overload_fault | faults.disturbance;

	// run state
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			state_reg <= PFWS_STOPPED;
		else
		begin
			unique case (state_reg)
				PFWS_STOPPED, PFWS_DECEL:
					// warnings are not consulted here
					if (any_fault)
						state_reg <= PFWS_LOCKED;
					else if (start_req && !supply_low)
						state_reg <= PFWS_RUNNING;
					else if (state_reg == PFWS_DECEL && sense.speed_rpm == 16'h0000)
						state_reg <= PFWS_STOPPED;
				PFWS_RUNNING:
					if (any_fault)
						state_reg <= PFWS_LOCKED;
					else if (loss_hi_reg || loss_lo_reg)
						state_reg <= PFWS_DECEL;
				PFWS_LOCKED:
					// only a reset with every fault gone releases the lock
					if (fault_reset_req && !fault_cause)
						state_reg <= PFWS_STOPPED;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			decel_cmd <= 1'b0;
			accel_cmd <= 1'b0;
		end
		else
		begin
			decel_cmd <= (state_reg == PFWS_DECEL) || (state_reg == PFWS_LOCKED);
			accel_cmd <= (state_reg == PFWS_RUNNING);
		end
	end

	// damage score, saturating
	always_comb
	begin
		dist_pts = {4'h0, sense.speed_rpm[15:12]};
		if (dist_pts > {4'h0, DAMAGE_DIST_MAX})
			dist_pts = {4'h0, DAMAGE_DIST_MAX};
		if (dist_pts == 8'h00)
			dist_pts = 8'h01;
	end

	assign damage_sum = {1'b0, damage_score}
		+ (dist_event ? {1'b0, dist_pts} : 9'h000)
		+ (land_event ? {1'b0, DAMAGE_LAND_PTS} : 9'h000);

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			damage_score <= 8'h00;
		else if (damage_sum > {1'b0, DAMAGE_MAX})
			damage_score <= DAMAGE_MAX;
		else
			damage_score <= damage_sum[7:0];
	end

	// running hours, saturating
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			hour_cnt_reg <= 32'h0000_0000;
			run_hours    <= 32'h0000_0000;
		end
		else if (tick && state_reg == PFWS_RUNNING)
		begin
			if (hour_cnt_reg >= HOUR_LEN - 1)
			begin
				hour_cnt_reg <= 32'h0000_0000;
				if (run_hours != RUNTIME_MAX)
					run_hours <= run_hours + 32'h0000_0001;
			end
			else
				hour_cnt_reg <= hour_cnt_reg + 32'h0000_0001;
		end
	end

	assign limit_hours = 32'(runtime_limit_steps) * 32'(RUNTIME_STEP_H);

	// warnings: set wins over clear; fault reset does not touch them
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			warnings <= '0;
		else
		begin
			if (warn_enable[2] && damage_score >= DAMAGE_LIMIT)
				warnings.damage_limit <= 1'b1;
			else if (warn_clear || !warn_enable[2])
				warnings.damage_limit <= 1'b0;
			if (warn_enable[1] && limit_hours != 32'h0000_0000 && run_hours >= limit_hours)
				warnings.runtime_over <= 1'b1;
			else if (warn_clear || !warn_enable[1] || limit_hours == 32'h0000_0000)
				warnings.runtime_over <= 1'b0;
			if (warn_enable[0] && sense.imbalance > IMBAL_LIMIT)
				warnings.imbalance <= 1'b1;
			else if (warn_clear || !warn_enable[0])
				warnings.imbalance <= 1'b0;
		end
	end

	// indication priorities
	always_comb
	begin
		if (lamps_dark)
			red_pat = PAT_OFF;
		else if (faults.power_fail || faults.overspeed)
			red_pat = PAT_STEADY;
		else if (faults.motor_overtemp || faults.controller_overtemp_fault)
			red_pat = 3'd3;
		else if (faults.driver_overload_fault)
			red_pat = 3'd2;
		else if (faults.disturbance)
			red_pat = 3'd1;
		else
			red_pat = PAT_OFF;
	end

	always_comb
	begin
		// a red failure indication takes the lamp over
		if (red_pat != PAT_OFF || lamps_dark)
			orange_pat = PAT_OFF;
		else if (warnings.damage_limit)
			orange_pat = 3'd3;
		else if (warnings.runtime_over)
			orange_pat = 3'd2;
		else if (warnings.imbalance)
			orange_pat = 3'd1;
		else
			orange_pat = PAT_OFF;
	end

	pfws_flash u_red
	(
		.clk    (clk),
		.arst_n (arst_n),
		.tick   (tick),
		.pattern(red_pat),
		.lamp   (failure_lamp_red)
	);

	pfws_flash u_orange
	(
		.clk    (clk),
		.arst_n (arst_n),
		.tick   (tick),
		.pattern(orange_pat),
		.lamp   (failure_lamp_orange)
	);

	// power lamp and remote contacts
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			power_lamp        <= 1'b0;
			power_good_closed <= 1'b0;
			failure_no_closed <= 1'b0;
			failure_nc_closed <= 1'b1;
			warning_out       <= 1'b0;
		end
		else
		begin
			// short losses at high speed keep everything as it was
			if (!supply_low)
			begin
				power_lamp        <= 1'b1;
				power_good_closed <= 1'b1;
			end
			else if (loss_hi_reg || loss_lo_reg)
			begin
				power_lamp        <= 1'b0;
				power_good_closed <= 1'b0;
			end
			failure_no_closed <= loss_hi_reg | any_fault;
			failure_nc_closed <= !(loss_hi_reg | any_fault);
			warning_out       <= |warnings;
		end
	end

endmodule : pfws_supervisor

//--- pfws_supervisor_chk.sv
/*
 Port-level checker for the supervisor.
 Assumes one clock domain and the async low reset of the top module.
*/
`timescale 1ns/1ps
module pfws_supervisor_chk
	import pfws_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYC,
	parameter int unsigned LOSS_TICKS  = PWR_LOSS_TICKS
)
(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             arst_n,
	// inputs watched
	input  pfws_pkg::pfws_sense_t sense,
	input  wire logic             fault_reset_req,
	input  wire logic             warn_clear,
	input  wire logic [2:0]       warn_enable,
	// outputs watched
	input  wire logic             decel_cmd,
	input  wire logic             power_lamp,
	input  wire logic             failure_lamp_red,
	input  wire logic             power_good_closed,
	input  wire logic             failure_no_closed,
	input  wire logic             failure_nc_closed,
	input  wire logic             warning_out,
	input  pfws_pkg::pfws_fault_t faults,
	input  pfws_pkg::pfws_warn_t  warnings,
	input  wire logic [7:0]       damage_score
);
	localparam int LOSS_CYC = (LOSS_TICKS - 1) * TICK_CYCLES;
	logic [15:0] lo_cnt;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	// saturates so a very long outage cannot wrap back under the limit
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
			lo_cnt <= 16'h0;
		else if (sense.supply_dv >= SUPPLY_MIN_DV)
			lo_cnt <= 16'h0;
		else if (lo_cnt != 16'hFFFF)
			lo_cnt <= lo_cnt + 16'h1;

	sequence fail_rise;
		$rose(faults.power_fail);
	endsequence
	sequence dark_out;
		decel_cmd && !power_lamp && !power_good_closed && failure_no_closed && !failure_nc_closed;
	endsequence

	loss_dwell_a: assert property ($rose(faults.power_fail) |-> lo_cnt > LOSS_CYC)
		else $error("power failure flagged before the loss lasted long enough");
	loss_outputs_a: assert property (fail_rise |-> ##[1:2] dark_out)
		else $error("power failure outputs wrong");
	overspeed_a: assert property (sense.speed_rpm > SPEED_OVER_RPM
		|-> ##[1:3] faults.overspeed)
		else $error("overspeed not flagged");
	motor_heat_a: assert property (sense.motor_temp_dc > MOTOR_MAX_DC
		|-> ##[1:3] faults.motor_overtemp)
		else $error("motor overheat not flagged");
	ctrl_heat_a: assert property (sense.ctrl_temp_dc > CTRL_MAX_DC
		|-> ##[1:3] faults.controller_overtemp_fault)
		else $error("controller overheat not flagged");
	fault_decel_a: assert property ($rose(|faults[4:0]) |-> ##[1:3] decel_cmd)
		else $error("fault without deceleration order");
	red_steady_a: assert property (faults.overspeed [*4] |-> failure_lamp_red)
		else $error("red lamp not steady on overspeed");
	warn_out_a: assert property ((|warnings) [*2] |-> warning_out)
		else $error("warning output missing");
	warn_keep_a: assert property (fault_reset_req && !warn_clear && warn_enable[2]
		&& warnings.damage_limit |=> warnings.damage_limit)
		else $error("fault reset cleared a warning");
	damage_mono_a: assert property (damage_score >= $past(damage_score))
		else $error("damage score went down");
	damage_lim_a: assert property (damage_score >= DAMAGE_LIMIT && warn_enable[2]
		|-> ##[1:2] warnings.damage_limit)
		else $error("damage limit warning missing");
endmodule : pfws_supervisor_chk

bind pfws_supervisor pfws_supervisor_chk #(.TICK_CYCLES(TICK_CYCLES), .LOSS_TICKS(LOSS_TICKS)) chk (
	.clk(clk), .arst_n(arst_n), .sense(sense), .fault_reset_req(fault_reset_req),
	.warn_clear(warn_clear), .warn_enable(warn_enable), .decel_cmd(decel_cmd),
	.power_lamp(power_lamp), .failure_lamp_red(failure_lamp_red),
	.power_good_closed(power_good_closed), .failure_no_closed(failure_no_closed),
	.failure_nc_closed(failure_nc_closed), .warning_out(warning_out), .faults(faults),
	.warnings(warnings), .damage_score(damage_score));

//--- tb_pfws_supervisor.sv
/*
 Self-checking bench for the supervisor with shortened timing parameters.
 Assumes the pump model supplies the sensor word from bench readings.
*/
`timescale 1ns/1ps
module tb_pfws_supervisor;
	import pfws_pkg::*;
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin n_errors++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, a); end end

	logic                   clk, arst_n, start_req, fault_reset_req, warn_clear;
	logic [2:0]             warn_enable;
	logic [15:0]            runtime_limit_steps;
	pfws_sense_t            knob, base, sense;
	logic                   decel_cmd, accel_cmd, power_lamp, lamp_red, lamp_org;
	logic                   pg_closed, no_closed, nc_closed, warning_out;
	pfws_fault_t            faults;
	pfws_warn_t             warnings;
	logic [7:0]             damage_score;
	logic [31:0]            run_hours;
	logic [5:0]             exp_f [6] = '{6'h10, 6'h08, 6'h04, 6'h01, 6'h01, 6'h02};
	int                     n_errors, check_count;

	pfws_pump_model model (.knob(knob), .accel_cmd(accel_cmd), .decel_cmd(decel_cmd), .sense(sense));
	pfws_supervisor #(.TICK_CYCLES(2), .LOSS_TICKS(4), .OVLD_LIMIT(10), .CONT_TICKS(3),
		.HOUR_LEN(5)) dut (
		.clk(clk), .arst_n(arst_n), .sense(sense), .start_req(start_req),
		.fault_reset_req(fault_reset_req), .warn_enable(warn_enable), .warn_clear(warn_clear),
		.runtime_limit_steps(runtime_limit_steps), .decel_cmd(decel_cmd), .accel_cmd(accel_cmd),
		.power_lamp(power_lamp), .failure_lamp_red(lamp_red), .failure_lamp_orange(lamp_org),
		.power_good_closed(pg_closed), .failure_no_closed(no_closed),
		.failure_nc_closed(nc_closed), .warning_out(warning_out), .faults(faults),
		.warnings(warnings), .damage_score(damage_score), .run_hours(run_hours));

	always #5 clk = ~clk;

	task wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wt
	task start_pulse;
		@(posedge clk) start_req <= 1'b1;
		@(posedge clk) start_req <= 1'b0;
	endtask : start_pulse
	task reset_pulse;
		@(posedge clk) fault_reset_req <= 1'b1;
		@(posedge clk) fault_reset_req <= 1'b0;
	endtask : reset_pulse
	task set_supply(input logic [15:0] v);
		@(posedge clk) knob.supply_dv <= v;
	endtask : set_supply
	task close_out;
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out

	// generous bound: the whole sequence needs about 1750 cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		n_errors++;
		close_out();
	end

	initial
	begin
		clk = 1'b0; arst_n = 1'b0; start_req = 1'b0; fault_reset_req = 1'b0; warn_clear = 1'b0;
		warn_enable = 3'b111; runtime_limit_steps = 16'h0;
		// above rated speed so no driver overload builds up in the power-loss tests
		base = '0; base.supply_dv = 16'd480; base.speed_rpm = 16'd46000;
		base.motor_temp_dc = 12'd300; base.ctrl_temp_dc = 12'd300; base.bearing_ok = 1'b1;
		knob = base;
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		wt(3);
		`CHK("idle_out", 3'b101, {power_lamp, no_closed, nc_closed})
		start_pulse(); wt(3);
		`CHK("accel", 1'b1, accel_cmd)
		// outage shorter than the loss window
		set_supply(16'd400); wt(4); set_supply(16'd480); wt(12);
		`CHK("short_loss", 7'h01, {faults, power_lamp})
		set_supply(16'd400); wt(16);
		`CHK("loss_out", 6'b110010, {faults.power_fail, decel_cmd, power_lamp, pg_closed, no_closed,
			nc_closed})
		set_supply(16'd480); wt(4);
		`CHK("recover", 7'b0110101, {faults.power_fail, decel_cmd, power_lamp, lamp_red, pg_closed,
			no_closed, nc_closed})
		start_pulse(); wt(3);
		`CHK("reaccel", 2'b10, {accel_cmd, decel_cmd})
		set_supply(16'd400); wt(16);
		@(posedge clk) knob.speed_rpm <= 16'd15000;
		wt(4);
		`CHK("landed", 3'b000, {power_lamp, lamp_red, lamp_org})
		`CHK("land_pts", 8'd1, damage_score)
		base.speed_rpm = 16'd30000;
		@(posedge clk) knob <= base;
		reset_pulse(); wt(4);
		for (int i = 0; i < 6; i++)
		begin
			@(posedge clk)
			case (i)
				0: knob.speed_rpm <= 16'd59000;
				1: knob.motor_temp_dc <= 12'd1200;
				2: knob.ctrl_temp_dc <= 12'd900;
				3: knob.bearing_ok <= 1'b0;
				4: knob.contact <= 1'b1;
				default: start_req <= 1'b1;
			endcase
			@(posedge clk) start_req <= 1'b0;
			wt(40);
			`CHK("fault", exp_f[i], faults)
			`CHK("fail_out", 3'b110, {decel_cmd, no_closed, nc_closed})
			@(posedge clk) knob <= base;
			reset_pulse(); wt(4);
			`CHK("cleared", 6'h00, faults)
		end
		`CHK("dist_pts", 8'd15, damage_score)
		// 0xE000 rpm earns fourteen points per disturbance
		base.speed_rpm = 16'hE000;
		@(posedge clk) knob <= base;
		repeat (8)
		begin
			@(posedge clk) knob.bearing_ok <= 1'b0;
			wt(6);
			@(posedge clk) knob.bearing_ok <= 1'b1;
			reset_pulse(); wt(4);
		end
		`CHK("dmg", 8'd127, damage_score)
		`CHK("dmg_warn", 2'b11, {warnings.damage_limit, warning_out})
		reset_pulse(); wt(3);
		`CHK("warn_kept", 1'b1, warnings.damage_limit)
		start_pulse(); wt(3);
		`CHK("warn_run", 1'b1, accel_cmd)
		@(posedge clk) knob.imbalance <= 12'h300;
		wt(4);
		`CHK("imbal", 3'b101, warnings)
		@(posedge clk) knob.imbalance <= 12'h0;
		@(posedge clk) warn_clear <= 1'b1;
		@(posedge clk) warn_clear <= 1'b0;
		wt(3);
		`CHK("cleared_w", 3'b100, warnings)
		@(posedge clk) runtime_limit_steps <= 16'h1;
		// three-pulse damage burst: first pulse lit from about 400 to 800 cycles in
		wt(600);
		`CHK("orange", 1'b1, lamp_org)
		wt(600);
		`CHK("runtime", 1'b1, warnings.runtime_over)
		`CHK("hours", 1'b1, run_hours >= 32'd100)
		// loss below landing speed is not flagged as a power failure
		@(posedge clk)
		begin
			knob.speed_rpm <= 16'd15000;
			knob.supply_dv <= 16'd400;
		end
		wt(16);
		`CHK("low_loss", 6'b000001, {faults.power_fail, power_lamp, lamp_red, pg_closed, no_closed,
			nc_closed})
		close_out();
	end
endmodule : tb_pfws_supervisor
